// ===== adc_cfg_consts.svh
/*
  register offsets, field positions, reset values and the pattern
  selector code for the converter configuration register slice.
  assumes: included by its bare name; definitions only.
*/
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH

// register offsets (byte addresses on the 8-bit register port)
`define OFS_UPPER_ADDR 8'h67
`define PAIR_CTRL_ADDR 8'h68
`define RECAL_CTRL_ADDR 8'h6b
`define PLL_PHASE_ADDR 8'h6d
`define PAT_A_LOW_ADDR 8'h74
`define PAT_A_HIGH_ADDR 8'h75
`define PAT_B_LOW_ADDR 8'h76
`define PAT_B_HIGH_ADDR 8'h77
`define IQ_CTRL_ADDR 8'h79
`define DECIM1_CTRL_ADDR 8'h7a
`define CAL_STAT_ADDR 8'hd1

// reset values, factory bits included
`define OFS_UPPER_RST 8'h00
`define PAIR_CTRL_RST 8'h24
`define RECAL_CTRL_RST 8'h08
`define PLL_PHASE_RST 8'h00
`define PAT_RST 8'h00
`define IQ_CTRL_RST 8'h00
`define DECIM1_CTRL_RST 8'h00

// field positions
`define PAIR_POL_BIT 3
`define PAIR_EN_BIT 2
`define RECAL_BIT 2
`define PLL_CLK_EN_BIT 5
`define DLY_MSB 3
`define DLY_LSB 1
`define PHASE_IMPL_MASK 8'h3f
`define PAT_LOW_MSB 7
`define PAT_LOW_LSB 2
`define IQ_EN_BIT 7
`define DECIM1_BIT 6
`define CAL_STAT_BIT 0

// test pattern selector code for alternating custom patterns
`define PAT_SEL_DOUBLE 3'h1

`endif

// ===== adc_cfg_pkg.sv
/*
  types shared by the converter configuration register slice.
  assumes: compiled after adc_cfg_consts.svh is available.
*/
package adc_cfg_pkg;

  typedef logic [7:0] byte_t;

  // over-range / word-clock output pair
  typedef struct packed {
    logic over_range_flag;
    logic word_clock_out;
    logic oe;
  } flag_pair_s;

  // one register port access
  typedef struct packed {
    byte_t addr;
    byte_t wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage : adc_cfg_pkg

// ===== adc_cfg_regs.sv
/*
  configuration register slice of a pipelined converter: offset upper
  byte, output pair control, pll recalibration and output clock phase,
  two custom test patterns, i/q post-processing and first decimation bit,
  with the offset adder and custom pattern output path they steer.
  assumes: one clock, synchronous active-high reset, a register port
  whose strobes are one cycle long; the lower offset byte, pattern
  selector, clock source selection and pll status come in as levels.
*/
// Overview of operation
// - upper offset byte register holds offset bits 15..8, resets to zero
// - signed 16-bit offset added to samples, one count is quarter LSb
// - in lvds mode the flag pair is inverted when polarity bit set
// - flag pair driven only while its enable bit is one (reset one)
// - any change of the recalibration bit starts a pll calibration
// - calibration progress is readable as a flag in another register
// - pll clock reaches the core only when its enable bit is one
// - three-bit code selects output clock delay of 0 to 15 vco cycles
// - pll output settings act only with pll source and pll enabled
// - clock delay applies only with pll source and no decimation
// - bits 7 and 6 of pll phase register read back as zero
// - pattern a low bits 5..0 sit in bits 7..2; bits 1..0 reset zero
// - pattern a upper register holds bits 13..6, resets to zero
// - pattern b low bits 5..0 sit in bits 7..2; bits 1..0 reset zero
// - pattern b upper register holds bits 13..6, resets to zero
// - double custom mode alternates pattern a and b on the outputs
// - pattern bit 13 drives over-range, bit 12 drives word clock
// - i/q post-processing enabled only when its bit is one
// - first-stage decimation bit enables stage 1a, default zero
// - decimation enables are a thermometer code, each stage halves rate
`timescale 1ns/10ps
`include "adc_cfg_consts.svh"

module adc_cfg_regs #(
  parameter int DATA_W = 14,
  parameter int FIR_UPPER_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // settings held elsewhere in the device
  input wire logic [7:0] offset_lower_byte,
  input wire logic [2:0] test_pattern_sel,
  input wire logic lvds_mode,
  input wire logic clk_source_pll,
  input wire logic pll_enable,
  input wire logic [FIR_UPPER_W-1:0] fir_upper_stages,
  input wire logic pll_cal_busy,
  // converter samples
  input wire logic [DATA_W-1:0] adc_data,
  input wire logic adc_over_range,
  // data outputs
  output logic [DATA_W-1:0] data_out,
  output adc_cfg_pkg::flag_pair_s flag_pair,
  output logic [3:0] unused_test_bits,
  // control outputs
  output logic [15:0] digital_offset_word,
  output logic pll_recal_start,
  output logic pll_clk_enable,
  output logic [3:0] out_clock_vco_delay,
  output logic iq_postprocess_enable,
  output logic first_decim_enable,
  output logic [3:0] decim_stage_count
);

  localparam int STAGES = FIR_UPPER_W + 1;
  localparam logic [DATA_W-1:0] SAT_MAX = {1'b0, {(DATA_W-1){1'b1}}};
  localparam logic [DATA_W-1:0] SAT_MIN = {1'b1, {(DATA_W-1){1'b0}}};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // delay code to vco cycles: 0,1 direct, 7 gives 15, others 2*code+2
  function automatic logic [3:0] dly_cycles(input logic [2:0] code);
    case (code)
      3'h0: dly_cycles = 4'h0;
      3'h1: dly_cycles = 4'h1;
      3'h7: dly_cycles = 4'hf;
      default: dly_cycles = 4'({code, 1'b0} + 4'h2);
    endcase
  endfunction : dly_cycles

  adc_cfg_pkg::reg_req_s req;
  assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

  // register storage
  logic [7:0] ofs_upper_r;
  logic [7:0] pair_ctrl_r;
  logic [7:0] recal_ctrl_r;
  logic [7:0] pll_phase_r;
  logic [7:0] pat_a_low_r;
  logic [7:0] pat_a_high_r;
  logic [7:0] pat_b_low_r;
  logic [7:0] pat_b_high_r;
  logic [7:0] iq_ctrl_r;
  logic [7:0] decim1_ctrl_r;
  logic recal_prev_r;
  logic alt_sel_r;
  logic wck_r;

  // write decode
  wire wr_ofs = req.wr && hit(req.addr, `OFS_UPPER_ADDR);
  wire wr_pair = req.wr && hit(req.addr, `PAIR_CTRL_ADDR);
  wire wr_recal = req.wr && hit(req.addr, `RECAL_CTRL_ADDR);
  wire wr_phase = req.wr && hit(req.addr, `PLL_PHASE_ADDR);
  wire wr_pal = req.wr && hit(req.addr, `PAT_A_LOW_ADDR);
  wire wr_pah = req.wr && hit(req.addr, `PAT_A_HIGH_ADDR);
  wire wr_pbl = req.wr && hit(req.addr, `PAT_B_LOW_ADDR);
  wire wr_pbh = req.wr && hit(req.addr, `PAT_B_HIGH_ADDR);
  wire wr_iq = req.wr && hit(req.addr, `IQ_CTRL_ADDR);
  wire wr_dec = req.wr && hit(req.addr, `DECIM1_CTRL_ADDR);

  always_ff @(posedge clk) begin
    if (srst) begin
      ofs_upper_r <= `OFS_UPPER_RST;
      pair_ctrl_r <= `PAIR_CTRL_RST;
      recal_ctrl_r <= `RECAL_CTRL_RST;
      pll_phase_r <= `PLL_PHASE_RST;
      pat_a_low_r <= `PAT_RST;
      pat_a_high_r <= `PAT_RST;
      pat_b_low_r <= `PAT_RST;
      pat_b_high_r <= `PAT_RST;
      iq_ctrl_r <= `IQ_CTRL_RST;
      decim1_ctrl_r <= `DECIM1_CTRL_RST;
    end else begin
      if (wr_ofs) ofs_upper_r <= req.wdata;
      if (wr_pair) pair_ctrl_r <= req.wdata;
      if (wr_recal) recal_ctrl_r <= req.wdata;
      if (wr_phase) pll_phase_r <= req.wdata & `PHASE_IMPL_MASK;
      if (wr_pal) pat_a_low_r <= req.wdata;
      if (wr_pah) pat_a_high_r <= req.wdata;
      if (wr_pbl) pat_b_low_r <= req.wdata;
      if (wr_pbh) pat_b_high_r <= req.wdata;
      if (wr_iq) iq_ctrl_r <= req.wdata;
      if (wr_dec) decim1_ctrl_r <= req.wdata;
    end
  end

  // read mux
  wire [7:0] stat_byte = 8'(pll_cal_busy) << `CAL_STAT_BIT;
  wire [7:0] rdata_nxt =
    hit(req.addr, `OFS_UPPER_ADDR) ? ofs_upper_r :
    hit(req.addr, `PAIR_CTRL_ADDR) ? pair_ctrl_r :
    hit(req.addr, `RECAL_CTRL_ADDR) ? recal_ctrl_r :
    hit(req.addr, `PLL_PHASE_ADDR) ? (pll_phase_r & `PHASE_IMPL_MASK) :
    hit(req.addr, `PAT_A_LOW_ADDR) ? pat_a_low_r :
    hit(req.addr, `PAT_A_HIGH_ADDR) ? pat_a_high_r :
    hit(req.addr, `PAT_B_LOW_ADDR) ? pat_b_low_r :
    hit(req.addr, `PAT_B_HIGH_ADDR) ? pat_b_high_r :
    hit(req.addr, `IQ_CTRL_ADDR) ? iq_ctrl_r :
    hit(req.addr, `DECIM1_CTRL_ADDR) ? decim1_ctrl_r :
    hit(req.addr, `CAL_STAT_ADDR) ? stat_byte : 8'h00;

  always_ff @(posedge clk) begin
    if (srst) rdata <= 8'h00;
    else if (req.rd) rdata <= rdata_nxt;
    else rdata <= 8'h00;
  end

  // split fields are plain concatenations, no staging
  wire [15:0] offset_nxt = {ofs_upper_r, offset_lower_byte};
  wire [13:0] pat_a = {pat_a_high_r,
    pat_a_low_r[`PAT_LOW_MSB:`PAT_LOW_LSB]};
  wire [13:0] pat_b = {pat_b_high_r,
    pat_b_low_r[`PAT_LOW_MSB:`PAT_LOW_LSB]};

  // recalibration on either transition of the trigger bit
  wire recal_now = recal_ctrl_r[`RECAL_BIT];
  wire recal_edge = recal_now ^ recal_prev_r;

  // pll gating and delay qualification
  wire pll_active = clk_source_pll && pll_enable;
  wire [STAGES-1:0] stage_bits =
    {fir_upper_stages, decim1_ctrl_r[`DECIM1_BIT]};
  wire decim_used = |stage_bits;
  wire [3:0] dly_nxt = (pll_active && !decim_used) ?
    dly_cycles(pll_phase_r[`DLY_MSB:`DLY_LSB]) : 4'h0;

  // thermometer count of enabled stages, one bit per halving
  logic [3:0] stage_cnt;
  always_comb begin
    stage_cnt = 4'h0;
    for (int i = 0; i < STAGES; i++) begin
      if (stage_bits[i]) stage_cnt = 4'(i + 1);
    end
  end

  // sample path: offset scaled by a quarter LSb, saturated
  wire signed [17:0] sum = $signed({{2{adc_data[DATA_W-1]}}, adc_data,
    2'b00}) + $signed({{2{offset_nxt[15]}}, offset_nxt});
  wire signed [17:0] q_sum = sum >>> 2;
  wire ovf_hi = !q_sum[17] && (q_sum > 18'sd8191);
  wire ovf_lo = q_sum[17] && (q_sum < -18'sd8192);
  wire [DATA_W-1:0] corr = ovf_hi ? SAT_MAX : ovf_lo ? SAT_MIN :
    q_sum[DATA_W-1:0];

  wire pat_mode = (test_pattern_sel == `PAT_SEL_DOUBLE);
  wire [13:0] pat_now = alt_sel_r ? pat_b : pat_a;
  wire [DATA_W-1:0] data_nxt = pat_mode ? pat_now : corr;
  wire ovr_raw = pat_mode ? pat_now[13] : adc_over_range;
  wire wck_raw = pat_mode ? pat_now[12] : wck_r;
  wire pair_inv = lvds_mode && pair_ctrl_r[`PAIR_POL_BIT];
  wire pair_on = pair_ctrl_r[`PAIR_EN_BIT];

  adc_cfg_pkg::flag_pair_s pair_nxt;
  assign pair_nxt.over_range_flag = pair_on & (ovr_raw ^ pair_inv);
  assign pair_nxt.word_clock_out = pair_on & (wck_raw ^ pair_inv);
  assign pair_nxt.oe = pair_on;

  always_ff @(posedge clk) begin
    if (srst) begin
      recal_prev_r <= 1'b0;
      pll_recal_start <= 1'b0;
      alt_sel_r <= 1'b0;
      wck_r <= 1'b0;
      data_out <= '0;
      flag_pair <= '0;
      digital_offset_word <= 16'h0000;
      pll_clk_enable <= 1'b0;
      out_clock_vco_delay <= 4'h0;
      iq_postprocess_enable <= 1'b0;
      first_decim_enable <= 1'b0;
      decim_stage_count <= 4'h0;
      unused_test_bits <= 4'h0;
    end else begin
      recal_prev_r <= recal_now;
      pll_recal_start <= recal_edge;
      alt_sel_r <= pat_mode ? !alt_sel_r : 1'b0;
      wck_r <= !wck_r;
      data_out <= data_nxt;
      flag_pair <= pair_nxt;
      digital_offset_word <= offset_nxt;
      pll_clk_enable <= pll_active && pll_phase_r[`PLL_CLK_EN_BIT];
      out_clock_vco_delay <= dly_nxt;
      iq_postprocess_enable <= iq_ctrl_r[`IQ_EN_BIT];
      first_decim_enable <= decim1_ctrl_r[`DECIM1_BIT];
      decim_stage_count <= stage_cnt;
      unused_test_bits <= {pat_b_low_r[1:0], pat_a_low_r[1:0]};
    end
  end

  // checks
  a_recal_pulse: assert property (@(posedge clk) disable iff (srst)
    $changed(recal_ctrl_r[`RECAL_BIT]) |=> pll_recal_start)
    else $error("recal toggle did not start calibration");
  a_recal_quiet: assert property (@(posedge clk) disable iff (srst)
    pll_recal_start |-> $past(recal_ctrl_r[`RECAL_BIT]) !=
      $past(recal_prev_r))
    else $error("calibration started without toggle");
  a_phase_top_zero: assert property (@(posedge clk) disable iff (srst)
    rd_stb && addr == `PLL_PHASE_ADDR |=> rdata[7:6] == 2'b00)
    else $error("pll phase bits 7..6 read nonzero");
  a_pair_disabled: assert property (@(posedge clk) disable iff (srst)
    !pair_ctrl_r[`PAIR_EN_BIT] |=> !flag_pair.oe &&
      !flag_pair.over_range_flag && !flag_pair.word_clock_out)
    else $error("flag pair driven while disabled");
  a_pair_invert: assert property (@(posedge clk) disable iff (srst)
    pair_on && pair_inv |=>
      flag_pair.over_range_flag == !$past(ovr_raw))
    else $error("flag pair polarity wrong");
  a_pll_clk_gate: assert property (@(posedge clk) disable iff (srst)
    pll_clk_enable |-> $past(pll_phase_r[`PLL_CLK_EN_BIT]) &&
      $past(clk_source_pll) && $past(pll_enable))
    else $error("pll clock enabled without its conditions");
  a_delay_decim: assert property (@(posedge clk) disable iff (srst)
    decim_used |=> out_clock_vco_delay == 4'h0)
    else $error("clock delay applied during decimation");
  a_delay_max: assert property (@(posedge clk) disable iff (srst)
    pll_active && !decim_used &&
      pll_phase_r[`DLY_MSB:`DLY_LSB] == 3'h7 |=>
      out_clock_vco_delay == 4'hf)
    else $error("delay code 7 not 15 cycles");
  a_pattern_alt: assert property (@(posedge clk) disable iff (srst)
    pat_mode ##1 pat_mode |=> alt_sel_r != $past(alt_sel_r) &&
      data_out == ($past(alt_sel_r) ? $past(pat_b) : $past(pat_a)))
    else $error("custom patterns do not alternate");
  a_offset_word: assert property (@(posedge clk) disable iff (srst)
    wr_ofs ##1 !wr_ofs |=> digital_offset_word[15:8] ==
      $past(wdata, 2))
    else $error("upper offset byte not applied");
  a_iq_enable: assert property (@(posedge clk) disable iff (srst)
    wr_iq |=> ##1 iq_postprocess_enable == $past(wdata[7], 2))
    else $error("iq enable does not follow its bit");
  a_decim_first: assert property (@(posedge clk) disable iff (srst)
    wr_dec |=> ##1 first_decim_enable == $past(wdata[6], 2))
    else $error("first decimation bit not applied");
  a_reset_clear: assert property (@(posedge clk)
    srst |=> digital_offset_word == 16'h0000 &&
      !pll_clk_enable && out_clock_vco_delay == 4'h0)
    else $error("outputs not cleared by reset");
  a_cal_status: assert property (@(posedge clk) disable iff (srst)
    rd_stb && addr == `CAL_STAT_ADDR |=>
      rdata[`CAL_STAT_BIT] == $past(pll_cal_busy))
    else $error("calibration status flag wrong");
  a_pair_enabled: assert property (@(posedge clk) disable iff (srst)
    pair_ctrl_r[`PAIR_EN_BIT] |=>
      flag_pair.oe)
    else $error("flag pair not driven while enabled");
  a_pair_plain: assert property (@(posedge clk) disable iff (srst)
    pair_on && !pair_inv |=>
      flag_pair.over_range_flag == $past(ovr_raw))
    else $error("flag pair inverted without polarity");
  a_wck_invert: assert property (@(posedge clk) disable iff (srst)
    pair_on && pair_inv |=>
      flag_pair.word_clock_out == !$past(wck_raw))
    else $error("word clock polarity wrong");
  a_pll_clk_off: assert property (@(posedge clk) disable iff (srst)
    !pll_phase_r[`PLL_CLK_EN_BIT] |=>
      !pll_clk_enable)
    else $error("pll clock enabled with its bit clear");
  a_delay_none: assert property (@(posedge clk) disable iff (srst)
    pll_phase_r[`DLY_MSB:`DLY_LSB] == 3'h0 |=>
      out_clock_vco_delay == 4'h0)
    else $error("delay code 0 not zero cycles");
  a_delay_one: assert property (@(posedge clk) disable iff (srst)
    pll_active && !decim_used && pll_phase_r[`DLY_MSB:`DLY_LSB] == 3'h1
      |=> out_clock_vco_delay == 4'h1)
    else $error("delay code 1 not one cycle");
  a_delay_fourteen: assert property (@(posedge clk) disable iff (srst)
    pll_active && !decim_used && pll_phase_r[`DLY_MSB:`DLY_LSB] == 3'h6
      |=> out_clock_vco_delay == 4'he)
    else $error("delay code 6 not 14 cycles");
  a_delay_no_pll: assert property (@(posedge clk) disable iff (srst)
    !pll_active |=>
      out_clock_vco_delay == 4'h0)
    else $error("clock delay applied without pll");
  a_pattern_first: assert property (@(posedge clk) disable iff (srst)
    pat_mode && !$past(pat_mode) |=>
      data_out == $past(pat_a))
    else $error("double pattern mode did not start with a");
  a_pattern_pins: assert property (@(posedge clk) disable iff (srst)
    pat_mode && pair_on && !pair_inv |=> flag_pair.over_range_flag ==
      data_out[DATA_W-1] && flag_pair.word_clock_out == data_out[DATA_W-2])
    else $error("pattern top bits not on flag pair");
  a_phase_store: assert property (@(posedge clk) disable iff (srst)
    wr_phase |=>
      pll_phase_r[7:6] == 2'b00)
    else $error("unimplemented phase bits stored");
  a_pat_a_low: assert property (@(posedge clk) disable iff (srst)
    wr_pal |=>
      pat_a_low_r[`PAT_LOW_MSB:`PAT_LOW_LSB] == $past(wdata[7:2]))
    else $error("pattern a low bits not stored");
  a_pat_b_low: assert property (@(posedge clk) disable iff (srst)
    wr_pbl |=>
      pat_b_low_r[`PAT_LOW_MSB:`PAT_LOW_LSB] == $past(wdata[7:2]))
    else $error("pattern b low bits not stored");
  a_pat_a_high: assert property (@(posedge clk) disable iff (srst)
    wr_pah |=>
      pat_a_high_r == $past(wdata))
    else $error("pattern a upper byte not stored");
  a_pat_b_high: assert property (@(posedge clk) disable iff (srst)
    wr_pbh |=>
      pat_b_high_r == $past(wdata))
    else $error("pattern b upper byte not stored");
  a_stage_none: assert property (@(posedge clk) disable iff (srst)
    !decim_used |=>
      decim_stage_count == 4'h0)
    else $error("stage count nonzero without stages");
  a_stage_all: assert property (@(posedge clk) disable iff (srst)
    &stage_bits |=>
      decim_stage_count == 4'(STAGES))
    else $error("stage count wrong with all stages");
  a_zero_offset: assert property (@(posedge clk) disable iff (srst)
    !pat_mode && offset_nxt == 16'h0000 |=>
      data_out == $past(adc_data))
    else $error("sample changed with zero offset");
  a_iq_off: assert property (@(posedge clk) disable iff (srst)
    !iq_ctrl_r[`IQ_EN_BIT] |=>
      !iq_postprocess_enable)
    else $error("iq processing enabled with bit clear");

endmodule : adc_cfg_regs

// ===== adc_cfg_regs_tb.sv
/*
  self-checking bench for the converter configuration register slice:
  a byte array model of the registers and integer models of the sample,
  pattern, delay, stage count and recalibration paths.
  assumes: adc_cfg_pkg compiled first, adc_cfg_consts.svh on the path.
*/
`timescale 1ns/10ps
`include "adc_cfg_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("wrong value t=%0t got %h exp %h", $time, g, e); \
  end end

module adc_cfg_regs_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr, wdata, rdata, offset_lower_byte, fir_upper_stages;
  logic wr_stb, rd_stb, lvds_mode, clk_source_pll, pll_enable;
  logic pll_cal_busy, adc_over_range, pll_recal_start, pll_clk_enable;
  logic iq_postprocess_enable, first_decim_enable;
  logic [2:0] test_pattern_sel;
  logic [13:0] adc_data, data_out, pa, pb, ex;
  adc_cfg_pkg::flag_pair_s flag_pair;
  logic [3:0] unused_test_bits, out_clock_vco_delay, decim_stage_count;
  logic [15:0] digital_offset_word, rnd = 16'h0021, ofs;
  logic [7:0] mdl [0:255];
  logic [7:0] alist [0:11];
  int n_mismatch = 0, check_count = 0, n_pulse = 0, i, k;

  always #20 clk = ~clk;
  always @(posedge clk) if (pll_recal_start === 1'b1) n_pulse = n_pulse + 1;

  adc_cfg_regs dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .offset_lower_byte(offset_lower_byte), .test_pattern_sel(test_pattern_sel),
    .lvds_mode(lvds_mode), .clk_source_pll(clk_source_pll),
    .pll_enable(pll_enable), .fir_upper_stages(fir_upper_stages),
    .pll_cal_busy(pll_cal_busy), .adc_data(adc_data),
    .adc_over_range(adc_over_range), .data_out(data_out),
    .flag_pair(flag_pair), .unused_test_bits(unused_test_bits),
    .digital_offset_word(digital_offset_word),
    .pll_recal_start(pll_recal_start), .pll_clk_enable(pll_clk_enable),
    .out_clock_vco_delay(out_clock_vco_delay),
    .iq_postprocess_enable(iq_postprocess_enable),
    .first_decim_enable(first_decim_enable),
    .decim_stage_count(decim_stage_count));

  function logic [15:0] rn();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction : rn

  function bit mapped(logic [7:0] a);
    for (int j = 0; j < 10; j++) if (alist[j] == a) return 1'b1;
    return 1'b0;
  endfunction : mapped

  function logic [13:0] sat_exp(logic [13:0] a, logic [15:0] o);
    int s;
    s = ($signed(a) * 4 + $signed(o)) >>> 2;
    if (s > 8191) s = 8191;
    if (s < -8192) s = -8192;
    return 14'(s);
  endfunction : sat_exp

  function logic [3:0] dly_exp(logic [2:0] c);
    if (c == 3'h0) return 4'h0;
    if (c == 3'h1) return 4'h1;
    if (c == 3'h7) return 4'hf;
    return 4'(2 * c + 2);
  endfunction : dly_exp

  // host writes touch user fields only; other bits keep their model value
  function logic [7:0] legal(logic [7:0] a, logic [7:0] d);
    logic [7:0] m;
    case (a)
      8'h68: m = 8'h0c;
      8'h6b: m = 8'h04;
      8'h6d: m = 8'hee;
      8'h74, 8'h76: m = 8'hfc;
      8'h79: m = mdl[8'h7a][6] ? 8'h00 : 8'h80;
      8'h7a: m = mdl[8'h79][7] ? 8'h00 : 8'h40;
      default: m = 8'hff;
    endcase
    return (d & m) | (mdl[a] & ~m);
  endfunction : legal

  task stop_test;
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk) wr_stb <= 1'b0;
    if (mapped(a)) mdl[a] = (a == `PLL_PHASE_ADDR) ? d & `PHASE_IMPL_MASK : d;
  endtask : wr

  task rd(input logic [7:0] a);
    logic [7:0] e;
    @(posedge clk) addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk) rd_stb <= 1'b0;
    e = mapped(a) ? mdl[a] : 8'h00;
    if (a == `CAL_STAT_ADDR) e = {7'h00, pll_cal_busy};
    @(negedge clk) `CHK(rdata, e)
    @(negedge clk) `CHK(rdata, 8'h00)
  endtask : rd

  task settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : settle

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    addr = 8'h00; wdata = 8'h00; wr_stb = 1'b0; rd_stb = 1'b0;
    offset_lower_byte = 8'h00; test_pattern_sel = 3'h0; lvds_mode = 1'b0;
    clk_source_pll = 1'b0; pll_enable = 1'b0; fir_upper_stages = 8'h00;
    pll_cal_busy = 1'b0; adc_data = 14'h0000; adc_over_range = 1'b0;
    alist = '{8'h67, 8'h68, 8'h6b, 8'h6d, 8'h74, 8'h75, 8'h76, 8'h77,
      8'h79, 8'h7a, 8'h70, 8'hd1};
    for (i = 0; i < 256; i++) mdl[i] = 8'h00;
    mdl[`PAIR_CTRL_ADDR] = `PAIR_CTRL_RST;
    mdl[`RECAL_CTRL_ADDR] = `RECAL_CTRL_RST;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    settle();
    `CHK(flag_pair.oe, 1'b1)
    `CHK(pll_clk_enable, 1'b0)
    for (i = 0; i < 12; i++) rd(alist[i]);
    @(posedge clk) pll_cal_busy <= 1'b1;
    rd(`CAL_STAT_ADDR);
    @(posedge clk) clk_source_pll <= 1'b1;
    pll_enable <= 1'b1;
    offset_lower_byte <= 8'(rn());
    for (i = 0; i < 30; i++) begin
      k = rn() % 12;
      wr(alist[k], legal(alist[k], 8'(rn())));
    end
    for (i = 0; i < 12; i++) rd(alist[i]);
    settle();
    `CHK(digital_offset_word, {mdl[8'h67], offset_lower_byte})
    `CHK(unused_test_bits, {mdl[8'h76][1:0], mdl[8'h74][1:0]})
    `CHK(iq_postprocess_enable, mdl[`IQ_CTRL_ADDR][7])
    `CHK(first_decim_enable, mdl[`DECIM1_CTRL_ADDR][6])
    `CHK(pll_clk_enable, mdl[`PLL_PHASE_ADDR][5])
    wr(`DECIM1_CTRL_ADDR, 8'h00);
    wr(`IQ_CTRL_ADDR, 8'h80);
    settle();
    `CHK(iq_postprocess_enable, 1'b1)
    wr(`IQ_CTRL_ADDR, 8'h00);
    @(posedge clk) fir_upper_stages <= 8'h00;
    for (k = 0; k < 8; k++) begin
      wr(`PLL_PHASE_ADDR, {4'h2, k[2:0], 1'b0});
      settle();
      `CHK(out_clock_vco_delay, dly_exp(k[2:0]))
    end
    @(posedge clk) fir_upper_stages <= 8'h01;
    settle();
    `CHK(out_clock_vco_delay, 4'h0)
    @(posedge clk) pll_enable <= 1'b0;
    settle();
    `CHK(pll_clk_enable, 1'b0)
    wr(`DECIM1_CTRL_ADDR, 8'h40);
    for (k = 0; k < 9; k++) begin
      @(posedge clk) fir_upper_stages <= 8'((1 << k) - 1);
      settle();
      `CHK(decim_stage_count, 4'(k + 1))
    end
    wr(`DECIM1_CTRL_ADDR, 8'h00);
    @(posedge clk) fir_upper_stages <= 8'h00;
    settle();
    `CHK(decim_stage_count, 4'h0)
    wr(`RECAL_CTRL_ADDR, mdl[`RECAL_CTRL_ADDR] ^ 8'h04);
    @(negedge clk) `CHK(pll_recal_start, 1'b0)
    @(negedge clk) `CHK(pll_recal_start, 1'b1)
    @(negedge clk) `CHK(pll_recal_start, 1'b0)
    n_pulse = 0;
    wr(`RECAL_CTRL_ADDR, mdl[`RECAL_CTRL_ADDR]);
    wr(`RECAL_CTRL_ADDR, mdl[`RECAL_CTRL_ADDR] ^ 8'h04);
    wr(`RECAL_CTRL_ADDR, mdl[`RECAL_CTRL_ADDR] ^ 8'h04);
    settle();
    settle();
    `CHK(n_pulse, 2)
    for (k = 0; k < 3; k++) begin
      ofs = (k == 0) ? rn() : (k == 1) ? 16'h7fff : 16'h8000;
      @(posedge clk) offset_lower_byte <= ofs[7:0];
      lvds_mode <= 1'b1;
      wr(`OFS_UPPER_ADDR, ofs[15:8]);
      wr(`PAIR_CTRL_ADDR, {4'h2, k[0], 3'h4});
      settle();
      `CHK(digital_offset_word, ofs)
      for (i = 0; i < 8; i++) begin
        ex = 14'(rn());
        @(posedge clk) adc_data <= ex;
        adc_over_range <= rnd[0];
        @(posedge clk);
        @(negedge clk) `CHK(data_out, sat_exp(ex, ofs))
        `CHK(flag_pair.over_range_flag, adc_over_range ^ k[0])
        `CHK(flag_pair.oe, 1'b1)
      end
    end
    wr(`PAIR_CTRL_ADDR, 8'h20);
    settle();
    `CHK(flag_pair, 3'h0)
    wr(`PAIR_CTRL_ADDR, `PAIR_CTRL_RST | 8'h08);
    pa = 14'(rn());
    pb = pa ^ 14'h2aaa;
    wr(`PAT_A_LOW_ADDR, {pa[5:0], 2'h0});
    wr(`PAT_A_HIGH_ADDR, pa[13:6]);
    wr(`PAT_B_LOW_ADDR, {pb[5:0], 2'h0});
    wr(`PAT_B_HIGH_ADDR, pb[13:6]);
    @(posedge clk) lvds_mode <= 1'b0;
    for (k = 0; k < 2; k++) begin
      @(posedge clk) test_pattern_sel <= 3'h0;
      @(posedge clk) test_pattern_sel <= `PAT_SEL_DOUBLE;
      @(posedge clk);
      for (i = 0; i < 5; i++) begin
        @(negedge clk) ex = (i % 2) ? pb : pa;
        `CHK(data_out, ex)
        `CHK(flag_pair.over_range_flag, ex[13])
        `CHK(flag_pair.word_clock_out, ex[12])
      end
    end
    `CHK(unused_test_bits, 4'h0)
    stop_test();
  end
endmodule : adc_cfg_regs_tb
